// ===== src/sac_adc_control.sv
// Converter control top: APB register slave, successive-approximation sequencer and
// result handling. Assumes an analog core that samples while sample_hold is high and
// raises comp_high, asynchronously, while the held input is at or above trial_code.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "sac_map.svh"
module sac_adc_control (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog core
  input wire logic comp_high,
  output logic analog_enable,
  output logic [3:0] mux_select,
  output logic sample_hold,
  output logic [9:0] trial_code
);
  localparam logic [11:0] ADDR_CSR = {2'b00, `SAC_IDX_CSR, 2'b00};
  localparam logic [11:0] ADDR_HIGH = {2'b00, `SAC_IDX_HIGH, 2'b00};
  localparam logic [11:0] ADDR_LOW = {2'b00, `SAC_IDX_LOW, 2'b00};

  sac_pkg::sac_state_t state_ff;
  logic done_ff;
  logic speed_ff;
  logic on_ff;
  logic slow_ff;
  logic [3:0] ch_ff;
  logic lock_ff;
  logic [9:0] res_ff;
  logic [9:0] sar_ff;
  logic [3:0] bit_idx_ff;
  logic [1:0] phase_ff;
  logic [31:0] prdata_ff;
  logic comp_sync;
  logic tick;
  logic access;
  logic setup_rd;
  logic hit_csr;
  logic hit_high;
  logic hit_low;
  logic hit_any;
  logic wr_csr;
  logic rd_high;
  logic rd_low;
  logic low_pending;
  logic start;
  logic stop;
  logic restart;
  logic phase_end;
  logic done_now;
  logic [9:0] decided;
  logic [9:0] next_trial;

  // Address decode and APB strobes.
  always_comb begin
    hit_csr = 1'b0;
    hit_high = 1'b0;
    hit_low = 1'b0;
    if (paddr == ADDR_CSR) begin
      hit_csr = 1'b1;
    end else if (paddr == ADDR_HIGH) begin
      hit_high = 1'b1;
    end else if (paddr == ADDR_LOW) begin
      hit_low = 1'b1;
    end
  end

  assign hit_any = hit_csr || hit_high || hit_low;
  assign access = psel && penable;
  assign setup_rd = psel && !penable && !pwrite;
  assign wr_csr = access && pwrite && hit_csr;
  assign rd_high = access && !pwrite && hit_high;
  assign rd_low = access && !pwrite && hit_low;
  assign low_pending = psel && !pwrite && hit_low;
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  assign prdata = prdata_ff;

  // Control events taken from a write to the control/status register.
  assign start = wr_csr && pwdata[`SAC_BIT_ON] && !on_ff;
  assign stop = wr_csr && !pwdata[`SAC_BIT_ON] && on_ff;
  assign restart = wr_csr && pwdata[`SAC_BIT_ON] && on_ff && (pwdata[3:0] != ch_ff);

  sac_sync u_comp_sync (
    .clk(clk),
    .reset(reset),
    .async_in(comp_high),
    .sync_out(comp_sync)
  );

  sac_clk_div u_clk_div (
    .clk(clk),
    .reset(reset),
    .run(on_ff),
    .slow(slow_ff),
    .speed(speed_ff),
    .tick(tick)
  );

  // Read data is captured in the setup phase so that it is stable in the access phase.
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_rd) begin
      if (hit_csr) begin
        prdata_ff <= {24'h00_0000, done_ff, speed_ff, on_ff, slow_ff, ch_ff};
      end else if (hit_high) begin
        prdata_ff <= {24'h00_0000, res_ff[9:2]};
      end else if (hit_low) begin
        prdata_ff <= {30'h0000_0000, res_ff[1:0]};
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // Software-written control fields; the done flag is not writable.
  always_ff @(posedge clk) begin
    if (reset) begin
      speed_ff <= 1'b0;
      on_ff <= 1'b0;
      slow_ff <= 1'b0;
      ch_ff <= 4'h0;
    end else if (wr_csr) begin
      speed_ff <= pwdata[`SAC_BIT_SPEED];
      on_ff <= pwdata[`SAC_BIT_ON];
      slow_ff <= pwdata[`SAC_BIT_SLOW];
      ch_ff <= pwdata[`SAC_CH_MSB:0];
    end
  end

  // Channel n drives mux input n directly.
  assign mux_select = ch_ff;
  assign analog_enable = on_ff;
  assign sample_hold = (state_ff == sac_pkg::ST_SAMPLE);
  assign trial_code = sar_ff;

  // Successive approximation: keep the trial bit while the held input is at or above it.
  // Inputs beyond either reference thus settle to all ones or all zeros.
  assign decided = comp_sync ? sar_ff : (sar_ff & ~(`SAC_BIT_ONE << bit_idx_ff));
  assign next_trial = decided | (`SAC_BIT_ONE << (bit_idx_ff - 4'h1));
  assign phase_end = tick && (phase_ff == `SAC_PHASE_LAST);
  assign done_now = (state_ff == sac_pkg::ST_CONVERT) && phase_end && (bit_idx_ff == 4'h0)
    && !restart && !stop;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= sac_pkg::ST_IDLE;
      phase_ff <= 2'h0;
      bit_idx_ff <= 4'h0;
      sar_ff <= 10'h000;
    end else if (stop || !on_ff && !start) begin
      state_ff <= sac_pkg::ST_IDLE;
      phase_ff <= 2'h0;
      bit_idx_ff <= 4'h0;
      sar_ff <= 10'h000;
    end else if (start || restart) begin
      state_ff <= sac_pkg::ST_SAMPLE;
      phase_ff <= 2'h0;
      bit_idx_ff <= 4'h0;
      sar_ff <= 10'h000;
    end else begin
      case (state_ff)
        sac_pkg::ST_SAMPLE: begin
          if (tick) begin
            phase_ff <= phase_ff + 2'h1;
          end
          if (phase_end) begin
            state_ff <= sac_pkg::ST_CONVERT;
            bit_idx_ff <= `SAC_RES_TOP;
            sar_ff <= `SAC_TRIAL_FIRST;
          end
        end
        sac_pkg::ST_CONVERT: begin
          if (tick) begin
            phase_ff <= phase_ff + 2'h1;
          end
          if (phase_end) begin
            if (bit_idx_ff == 4'h0) begin
              state_ff <= sac_pkg::ST_SAMPLE;
              sar_ff <= decided;
            end else begin
              bit_idx_ff <= bit_idx_ff - 4'h1;
              sar_ff <= next_trial;
            end
          end
        end
        default: begin
          state_ff <= sac_pkg::ST_SAMPLE;
          phase_ff <= 2'h0;
        end
      endcase
    end
  end

  // Done flag: a finishing conversion wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      done_ff <= 1'b0;
    end else if (done_now) begin
      done_ff <= 1'b1;
    end else if (wr_csr || rd_high) begin
      done_ff <= 1'b0;
    end
  end

  // Result lock: a pending low-byte read also holds off an update, so the low byte
  // captured in setup and the high byte read later belong to one sample.
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_ff <= 1'b0;
    end else if (rd_high || stop || !on_ff) begin
      lock_ff <= 1'b0;
    end else if (rd_low) begin
      lock_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      res_ff <= `SAC_RESULT_RESET;
    end else if (done_now && !lock_ff && !low_pending) begin
      res_ff <= decided;
    end
  end

  AST_DONE_SETS: assert property (@(posedge clk) disable iff (reset)
    done_now |=> done_ff)
    else $error("done flag not set after conversion");

  AST_HIGH_READ_CLEARS: assert property (@(posedge clk) disable iff (reset)
    (rd_high && !done_now) |=> !done_ff)
    else $error("high byte read did not clear done flag");

  AST_CSR_WRITE_CLEARS: assert property (@(posedge clk) disable iff (reset)
    (wr_csr && !done_now) |=> !done_ff)
    else $error("control write did not clear done flag");

  AST_CHANNEL_ABORT: assert property (@(posedge clk) disable iff (reset)
    restart |=> (state_ff == sac_pkg::ST_SAMPLE) && (phase_ff == 2'h0) && !done_ff
      && (mux_select == $past(pwdata[3:0])))
    else $error("channel change did not restart conversion");

  AST_LOCK_HOLDS: assert property (@(posedge clk) disable iff (reset)
    (lock_ff && !rd_high) |=> $stable(res_ff))
    else $error("locked result changed");

  AST_LOW_LOCKS: assert property (@(posedge clk) disable iff (reset)
    (rd_low && on_ff && !stop) |=> lock_ff)
    else $error("low byte read did not lock results");

  AST_UNLOCK: assert property (@(posedge clk) disable iff (reset)
    (rd_high || stop) |=> !lock_ff)
    else $error("lock not released");

  AST_OFF_IDLE: assert property (@(posedge clk) disable iff (reset)
    !on_ff |-> (state_ff == sac_pkg::ST_IDLE) && !done_now)
    else $error("converter active while off");

  AST_CONTINUOUS: assert property (@(posedge clk) disable iff (reset)
    done_now |=> (state_ff == sac_pkg::ST_SAMPLE) && (phase_ff == 2'h0))
    else $error("conversion did not restart after done");

  AST_UPDATE_RESULT: assert property (@(posedge clk) disable iff (reset)
    (done_now && !lock_ff && !low_pending) |=> (res_ff == $past(decided)))
    else $error("result not stored");

  AST_LOW_UPPER_ZERO: assert property (@(posedge clk) disable iff (reset)
    (setup_rd && hit_low) |=> (prdata_ff[31:2] == 30'h0000_0000) && (prdata_ff[1:0] == $past(res_ff[1:0])))
    else $error("low byte read data wrong");

  AST_CSR_READ: assert property (@(posedge clk) disable iff (reset)
    (setup_rd && hit_csr) |=> (prdata_ff[7] == $past(done_ff)) && (prdata_ff[3:0] == $past(ch_ff)))
    else $error("control read data wrong");

  // Checks on reset values, register fields and the order of the conversion sequence.
  AST_RESET_VALUES: assert property (@(posedge clk)
    reset |=> !done_ff && !speed_ff && !on_ff && !slow_ff && !lock_ff
      && (ch_ff == 4'h0) && (res_ff == `SAC_RESULT_RESET))
    else $error("control state not cleared by reset");

  AST_WRITE_FIELDS: assert property (@(posedge clk) disable iff (reset)
    wr_csr |=> (speed_ff == $past(pwdata[`SAC_BIT_SPEED])) && (on_ff == $past(pwdata[`SAC_BIT_ON]))
      && (slow_ff == $past(pwdata[`SAC_BIT_SLOW])))
    else $error("control fields not written");

  AST_READ_UPPER_ZERO: assert property (@(posedge clk) disable iff (reset)
    setup_rd |=> (prdata_ff[31:8] == 24'h00_0000))
    else $error("read data above bit 7 not zero");

  AST_HIGH_BYTE: assert property (@(posedge clk) disable iff (reset)
    (setup_rd && hit_high) |=> (prdata_ff[7:0] == $past(res_ff[9:2])))
    else $error("high byte read data wrong");

  AST_MUX_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
    wr_csr |=> (mux_select == $past(pwdata[3:0])))
    else $error("multiplexer select does not follow channel field");

  AST_MUX_HOLDS: assert property (@(posedge clk) disable iff (reset)
    !wr_csr |=> $stable(mux_select))
    else $error("multiplexer select changed without a write");

  AST_START_SAMPLES: assert property (@(posedge clk) disable iff (reset)
    start |=> (state_ff == sac_pkg::ST_SAMPLE) && analog_enable && sample_hold)
    else $error("converter did not start sampling");

  AST_STOP_IDLE: assert property (@(posedge clk) disable iff (reset)
    stop |=> (state_ff == sac_pkg::ST_IDLE) && !analog_enable && !sample_hold
      && !lock_ff && (trial_code == 10'h000))
    else $error("converter still active after stop");

  AST_DONE_HOLDS: assert property (@(posedge clk) disable iff (reset)
    (done_ff && !wr_csr && !rd_high) |=> done_ff)
    else $error("done flag lost without a clear");

  AST_RESULT_STABLE: assert property (@(posedge clk) disable iff (reset)
    !done_now |=> $stable(res_ff))
    else $error("result changed without a finished conversion");

  AST_LOCK_STICKY: assert property (@(posedge clk) disable iff (reset)
    (lock_ff && on_ff && !rd_high && !stop) |=> lock_ff)
    else $error("lock released early");

  AST_KEEP_TRIAL: assert property (@(posedge clk) disable iff (reset)
    ((state_ff == sac_pkg::ST_CONVERT) && phase_end && comp_sync && !restart && !stop)
      |=> ((sar_ff & $past(sar_ff)) == $past(sar_ff)))
    else $error("passed trial bit dropped");

  AST_DROP_TRIAL: assert property (@(posedge clk) disable iff (reset)
    ((state_ff == sac_pkg::ST_CONVERT) && phase_end && !comp_sync && !restart && !stop)
      |=> ((sar_ff & (`SAC_BIT_ONE << $past(bit_idx_ff))) == 10'h000))
    else $error("failed trial bit kept");

  AST_FIRST_TRIAL: assert property (@(posedge clk) disable iff (reset)
    ((state_ff == sac_pkg::ST_SAMPLE) && phase_end && !restart && !stop)
      |=> (state_ff == sac_pkg::ST_CONVERT) && (bit_idx_ff == `SAC_RES_TOP) && (trial_code == `SAC_TRIAL_FIRST))
    else $error("conversion did not begin with the top trial");

  AST_TRIAL_STEADY: assert property (@(posedge clk) disable iff (reset)
    ((state_ff == sac_pkg::ST_CONVERT) && !phase_end && !restart && !stop) |=> $stable(trial_code))
    else $error("trial code changed inside a bit period");
endmodule

// ===== src/sac_map.svh
// Constants for the converter control block: register indices, field positions,
// reset values and timing counts. Assumes inclusion by bare name from the design files.
//
// Contract
// - Each result is held as a 10-bit value split over high and low bytes.
// - Input above high reference returns FFh high byte and 03h low byte.
// - Input below low reference returns zero in both result bytes.
// - Setting converter_on starts conversions, repeated continuously on the selected channel.
// - Clearing converter_on disables the converter and stops all conversion activity.
// - Each finished conversion sets the done flag and stores the new result.
// - Reading the high result byte clears the done flag.
// - Any write to the control/status register clears the done flag.
// - Changing channel_select mid-conversion aborts it, clears done, restarts on new channel.
// - Reading the low result byte locks both result bytes against updates.
// - Reading the high byte or clearing converter_on releases the lock.
// - While locked, results are not updated until the high byte is read.
// - Slow/speed pair picks converter clock: CPU/2, CPU, CPU/4, CPU/2.
// - Control/status resets to 00h, read/write except read-only done flag bit 7.
// - A 4-bit channel_select field picks one of 16 analog inputs.
// - CPU wait mode leaves the converter running unchanged.
// - High byte holds bits 9..2; low byte holds bits 1..0, upper six zero.
// - channel_select value n selects analog input n, binary, 0 to 15.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

`define SAC_IDX_CSR 8'h45
`define SAC_IDX_HIGH 8'h46
`define SAC_IDX_LOW 8'h47
`define SAC_CSR_RESET 8'h00
`define SAC_RESULT_RESET 10'h000
`define SAC_BIT_DONE 7
`define SAC_BIT_SPEED 6
`define SAC_BIT_ON 5
`define SAC_BIT_SLOW 4
`define SAC_CH_MSB 3
`define SAC_RES_BITS 10
`define SAC_RES_TOP 4'h9
`define SAC_PHASE_LAST 2'h3
`define SAC_TRIAL_FIRST 10'h200
`define SAC_BIT_ONE 10'h001

`endif

// ===== src/sac_pkg.sv
// Types shared by the converter control block.
// Assumes nothing of its surroundings.
package sac_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } sac_state_t;
endpackage

// ===== src/sac_sync.sv
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the level changes slowly compared with two clock periods.
`timescale 1ns/10ps
module sac_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

// ===== src/sac_clk_div.sv
// Converter clock divider producing a one-cycle tick per converter clock period.
// Assumes run, slow and speed come from registers on the same clock.
`timescale 1ns/10ps
module sac_clk_div (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic slow,
  input wire logic speed,
  // Converter clock tick
  output logic tick
);
  logic [1:0] cnt_ff;
  logic [1:0] last;

  // Terminal count: 00 and 11 divide by 2, 01 passes the CPU clock, 10 divides by 4.
  always_comb begin
    last = 2'h1;
    if (!slow && speed) begin
      last = 2'h0;
    end else if (slow && !speed) begin
      last = 2'h3;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !run) begin
      cnt_ff <= 2'h0;
    end else if (cnt_ff >= last) begin
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end

  assign tick = run && (cnt_ff >= last);

  AST_DIV_FULL_RATE: assert property (@(posedge clk) disable iff (reset)
    (run && !slow && speed) |-> tick)
    else $error("converter clock not at CPU rate");

  AST_DIV_QUARTER: assert property (@(posedge clk) disable iff (reset)
    (tick && run && slow && !speed) ##1 (run && slow && !speed) |-> !tick)
    else $error("converter clock too fast in divide by four");
endmodule

// ===== dv/sac_core_model.sv
// Behavioural analog core: input multiplexer, sample-and-hold and comparator.
// Assumes the bench supplies one 11-bit level per input; values above 3ffh stand for overrange.
`timescale 1ns/10ps
module sac_core_model (
  // Clock
  input wire logic clk,
  // Control from the converter block
  input wire logic analog_enable,
  input wire logic [3:0] mux_select,
  input wire logic sample_hold,
  input wire logic [9:0] trial_code,
  // Analog levels of the inputs
  input wire logic [10:0] level [16],
  // Comparator
  output logic comp_high
);
  logic [10:0] held = 11'h000;
  logic flip = 1'b0;

  // The held level follows the selected input only while sampling.
  always_ff @(posedge clk) begin
    if (analog_enable && sample_hold) begin
      held <= level[mux_select];
    end
    flip <= ~flip;
  end

  // Overrange passes every trial and clamps to all ones; a powered-down core gives no stable answer.
  assign comp_high = analog_enable ? ({1'b0, trial_code} <= held) : flip;
endmodule

// ===== dv/sar_adc_control_bench.sv
// Self-checking bench for the converter control block over APB.
// Assumes the analog core model of sac_core_model.sv and a 100 MHz clock.
`timescale 1ns/10ps
module sar_adc_control_bench;
  typedef struct {logic [3:0] ch; logic [10:0] lv; logic [9:0] res;} sac_row_t;
  localparam logic [11:0] A_CSR = 12'h114;
  localparam logic [11:0] A_HIGH = 12'h118;
  localparam logic [11:0] A_LOW = 12'h11c;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, comp_high, analog_enable, sample_hold, last_err;
  logic [3:0] mux_select;
  logic [9:0] trial_code;
  logic [10:0] lvl [16];
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int per;
  sac_row_t rows [4] = '{
    '{4'h0, 11'h000, 10'h000},
    '{4'h5, 11'h155, 10'h155},
    '{4'ha, 11'h2aa, 10'h2aa},
    '{4'hf, 11'h500, 10'h3ff}};

  sac_adc_control dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_high(comp_high), .analog_enable(analog_enable), .mux_select(mux_select),
    .sample_hold(sample_hold), .trial_code(trial_code));
  sac_core_model core_u (.clk(clk), .analog_enable(analog_enable), .mux_select(mux_select),
    .sample_hold(sample_hold), .trial_code(trial_code), .level(lvl), .comp_high(comp_high));

  initial begin
    foreach (lvl[i]) lvl[i] = 11'h100;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_done();
    int n = 0;
    do begin
      apb(1'b0, A_CSR, 32'h0);
      n++;
    end while (q[7] !== 1'b1 && n < 300);
    chk("done", q[7], 1'b1);
  endtask

  // Reads low byte, then high byte, as software does for ten bits.
  task automatic rd_res(input logic [9:0] r);
    apb(1'b0, A_LOW, 32'h0);
    chk("low", q, {30'h0, r[1:0]});
    apb(1'b0, A_HIGH, 32'h0);
    chk("high", q, {24'h0, r[9:2]});
    apb(1'b0, A_CSR, 32'h0);
    chk("done_after_high", q[7], 1'b0);
  endtask

  // Counts rising edges from one entry into sampling to the next.
  task automatic rise();
    per = 0;
    do begin
      @(posedge clk);
      per++;
    end while (sample_hold !== 1'b0 && per < 900);
    do begin
      @(posedge clk);
      per++;
    end while (sample_hold !== 1'b1 && per < 900);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, A_CSR, 32'h0);
    chk("csr_reset", q, 32'h0);
    apb(1'b0, A_HIGH, 32'h0);
    chk("high_reset", q, 32'h0);
    apb(1'b0, 12'h120, 32'h0);
    chk("unmapped_err", last_err, 1'b1);
    apb(1'b1, A_CSR, 32'hdf);
    apb(1'b0, A_CSR, 32'h0);
    chk("csr_rw", q, 32'h5f);
    $display("test registers done");
    foreach (rows[i]) begin
      lvl[rows[i].ch] <= rows[i].lv;
      apb(1'b1, A_CSR, {24'h0, 4'h6, rows[i].ch});
      chk("mux", mux_select, rows[i].ch);
      chk("enable", analog_enable, 1'b1);
      wait_done();
      rd_res(rows[i].res);
    end
    $display("test table done");
    wait_done();
    apb(1'b1, A_CSR, 32'h6f);
    apb(1'b0, A_CSR, 32'h0);
    chk("done_after_write", q[7], 1'b0);
    apb(1'b1, A_CSR, 32'h65);
    repeat (20) @(posedge clk);
    lvl[10] <= 11'h0ff;
    apb(1'b1, A_CSR, 32'h6a);
    apb(1'b0, A_CSR, 32'h0);
    chk("done_after_switch", q[7], 1'b0);
    wait_done();
    rd_res(10'h0ff);
    $display("test channel switch done");
    wait_done();
    apb(1'b0, A_LOW, 32'h0);
    lvl[10] <= 11'h300;
    repeat (100) @(posedge clk);
    apb(1'b0, A_HIGH, 32'h0);
    chk("high_locked", q, 32'h3f);
    wait_done();
    rd_res(10'h300);
    wait_done();
    apb(1'b0, A_LOW, 32'h0);
    lvl[10] <= 11'h1c3;
    apb(1'b1, A_CSR, 32'h4a);
    chk("off_enable", analog_enable, 1'b0);
    repeat (100) @(posedge clk);
    chk("off_sampling", sample_hold, 1'b0);
    apb(1'b1, A_CSR, 32'h6a);
    wait_done();
    rd_res(10'h1c3);
    $display("test lock done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_CSR, {24'h0, 1'b0, i[0], 1'b1, i[1], 4'h3});
      rise();
      rise();
      chk("period", per, (i == 1) ? 44 : (i == 2) ? 176 : 88);
    end
    $display("test clock rates done");
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("rst_enable", analog_enable, 1'b0);
    chk("rst_sampling", sample_hold, 1'b0);
    chk("rst_trial", trial_code, 10'h000);
    chk("rst_ready", pready, 1'b1);
    apb(1'b0, A_CSR, 32'h0);
    chk("csr_rst_mid", q, 32'h0);
    apb(1'b0, A_LOW, 32'h0);
    chk("low_rst_mid", q, 32'h0);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
